// *** verilog/lsp_defs.svh ***
// Constants of the LED strobe pulse sequencer
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH
// Register byte offsets
`define LSP_ADR_CTRL     8'h00
`define LSP_ADR_STAT     8'h04
`define LSP_ADR_CUR      8'h08
`define LSP_ADR_LEN      8'h0C
`define LSP_ADR_DLY      8'h10
`define LSP_ADR_START    8'h14
`define LSP_ADR_CFG      8'h18
`define LSP_ADR_FIX      8'h1C
`define LSP_ADR_BLIND    8'h20
// Control word bits
`define LSP_CTRL_EN      0
`define LSP_CTRL_OUT     1
`define LSP_CTRL_TEN     2
// Configuration bits
`define LSP_CFG_TRIG     0
`define LSP_CFG_HWEN     1
`define LSP_CFG_FINE     2
`define LSP_CFG_FALL     3
`define LSP_CFG_LOW      4
// Status bits
`define LSP_STAT_RDY     0
`define LSP_STAT_LED     1
`define LSP_STAT_BUSY    2
`define LSP_STAT_BLIND   3
`define LSP_STAT_ARMED   4
// Writable masks and reset value
`define LSP_M_CTRL       32'h0000_0007
`define LSP_M_CFG        32'h0000_001F
`define LSP_M_16         32'h0000_FFFF
`define LSP_M_32         32'hFFFF_FFFF
`define LSP_RST_ZERO     32'h0000_0000
// Timing
`define LSP_CLK_MHZ      200
`define LSP_T_FINE_NS    100
`define LSP_T_US_NS      1000
`define LSP_T_OFS_NS     2000
`define LSP_BLIND_MIN_US 20
`define LSP_FINE_CYC     ((`LSP_T_FINE_NS * `LSP_CLK_MHZ) / `LSP_T_US_NS)
`define LSP_FINE_PER_US  (`LSP_T_US_NS / `LSP_T_FINE_NS)
`define LSP_OFS_FINE     (`LSP_T_OFS_NS / `LSP_T_FINE_NS)
`endif

// *** verilog/lsp_pkg.sv ***
// Types of the LED strobe pulse sequencer
`include "lsp_defs.svh"
package lsp_pkg;
    typedef enum logic [1:0] {
        LSP_IDLE  = 2'b00,
        LSP_DELAY = 2'b01,
        LSP_PULSE = 2'b10,
        LSP_BLIND = 2'b11
    } lsp_state_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } lsp_wb_req_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } lsp_wb_rsp_t;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] cfg;
        logic [31:0] cur;
        logic [31:0] len;
        logic [31:0] dly;
        logic [31:0] start;
        logic [31:0] fix;
        logic [31:0] blind;
    } lsp_regs_t;
    typedef struct packed {
        lsp_regs_t   rg;
        lsp_state_t  st;
        logic [19:0] cnt;
        logic        armed;
        logic        led;
        logic [15:0] cur_q;
        logic        ack;
        logic [31:0] rdat;
    } lsp_seq_st_t;
    typedef struct packed {
        logic [4:0] cyc;
        logic [3:0] sub;
    } lsp_tick_st_t;
    typedef struct packed {
        logic lvl;
        logic prv;
    } lsp_trig_st_t;
endpackage

// *** verilog/lsp_tick.sv ***
// Time base: 100 ns and 1 us strobes, restartable
`include "lsp_defs.svh"
module lsp_tick (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic clr_i,
    output logic      t100_o,
    output logic      tus_o
);
    import lsp_pkg::*;
    lsp_tick_st_t s;
    lsp_tick_st_t n;

    // Strobes on the last cycle of each period
    assign t100_o = (s.cyc == 5'(`LSP_FINE_CYC - 1));
    assign tus_o  = t100_o && (s.sub == 4'(`LSP_FINE_PER_US - 1));

    // Prescaler counting, restarted by clear
    always_comb begin
        n = s;
        if (clr_i) begin
            n = '0;
        end else if (t100_o) begin
            n.cyc = '0;
            n.sub = tus_o ? 4'h0 : s.sub + 4'h1;
        end else begin
            n.cyc = s.cyc + 5'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_fine_period: assert property (t100_o ##1 (!clr_i)[*8] ##0 1'b1 |-> !t100_o)
        else $error("100 ns strobe came early");
    a_us_align: assert property (tus_o |=> s.sub == 4'h0 && s.cyc == 5'h00)
        else $error("1 us strobe off the 100 ns grid");
endmodule

// *** verilog/lsp_trig.sv ***
// Trigger qualifier: level threshold select and edge detect
`include "lsp_defs.svh"
module lsp_trig (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hi_i,
    input  wire logic lo_i,
    input  wire logic low_sel_i,
    input  wire logic fall_sel_i,
    output logic      lvl_o,
    output logic      edge_o
);
    import lsp_pkg::*;
    lsp_trig_st_t s;
    lsp_trig_st_t n;

    always_comb begin
        n     = s;
        n.lvl = low_sel_i ? lo_i : hi_i;
        n.prv = s.lvl;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign lvl_o  = s.lvl;
    assign edge_o = fall_sel_i ? (s.prv && !s.lvl) : (!s.prv && s.lvl);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_level_select: assert property (1'b1 |=> lvl_o == ($past(low_sel_i) ? $past(lo_i) : $past(hi_i)))
        else $error("trigger level from wrong threshold");
    a_edge_dir: assert property (edge_o |-> (fall_sel_i ? $fell(s.lvl) : $rose(s.lvl)))
        else $error("trigger edge of wrong polarity");
endmodule

// *** verilog/lsp_seq.sv ***
// LED strobe pulse sequencer: register slave and pulse engine
`include "lsp_defs.svh"
module lsp_seq (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire lsp_pkg::lsp_wb_req_t wb_i,
    output lsp_pkg::lsp_wb_rsp_t      wb_o,
    input  wire logic [31:0]          sys_time_i,
    input  wire logic                 trigger_input_positive_hi_i,
    input  wire logic                 trigger_input_positive_lo_i,
    output logic                      led_output_channel_o,
    output logic [15:0]               led_current_o
);
    import lsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State and helpers
    lsp_seq_st_t s;
    lsp_seq_st_t n;
    logic [31:0] wm;
    logic [31:0] rdv;
    logic [31:0] diff;
    logic [19:0] dly_total;
    logic [19:0] pd_fine;
    logic [19:0] blind_eff;
    logic [15:0] len16;
    logic        t100;
    logic        tus;
    logic        ut;
    logic        clr;
    logic        lvl;
    logic        edg;
    logic        act;
    logic        trg;
    logic        hwen;
    logic        ten;
    logic        fine;
    logic        reached;
    logic        ready;
    logic        wr;

    ////////////////////////////////////////////////////////////////////////////
    // Sub-blocks
    lsp_tick u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (clr),
        .t100_o (t100),
        .tus_o  (tus)
    );

    lsp_trig u_trig (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .hi_i       (trigger_input_positive_hi_i),
        .lo_i       (trigger_input_positive_lo_i),
        .low_sel_i  (s.rg.cfg[`LSP_CFG_LOW]),
        .fall_sel_i (s.rg.cfg[`LSP_CFG_FALL]),
        .lvl_o      (lvl),
        .edge_o     (edg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Byte lane mask
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wm[8*b +: 8] = {8{wb_i.sel[b]}};
        end
    endgenerate

    // Merge write data under byte lanes and field mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
        merge = ((old & ~wm) | (wb_i.dat & wm)) & m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decoded settings
    // active when both enable and output bits are set
    assign act   = s.rg.ctrl[`LSP_CTRL_EN] && s.rg.ctrl[`LSP_CTRL_OUT];
    assign ten   = s.rg.ctrl[`LSP_CTRL_TEN];
    assign trg   = s.rg.cfg[`LSP_CFG_TRIG];
    assign hwen  = s.rg.cfg[`LSP_CFG_HWEN];
    assign fine  = s.rg.cfg[`LSP_CFG_FINE];
    assign len16 = s.rg.len[15:0];
    assign ready = (len16 != 16'h0000) && (s.rg.cur[15:0] != 16'h0000);
    assign wr    = wb_i.cyc && wb_i.stb && wb_i.we && s.ack;

    assign ut = fine ? t100 : tus;

    // data delay scaled to 100 ns
    assign pd_fine = fine ? 20'(s.rg.dly[15:0]) : 20'(s.rg.dly[15:0]) * 20'(`LSP_FINE_PER_US);
    assign dly_total = pd_fine + 20'(s.rg.fix[15:0]) + 20'(`LSP_OFS_FINE);

    assign blind_eff = (s.rg.blind[15:0] < 16'(`LSP_BLIND_MIN_US)) ?
                       20'(`LSP_BLIND_MIN_US) : 20'(s.rg.blind[15:0]);

    assign diff    = sys_time_i - s.rg.start;
    assign reached = !diff[31];

    // Prescaler restarts on each state change
    assign clr = (n.st != s.st);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rdv = `LSP_RST_ZERO;
        if (wb_i.adr == `LSP_ADR_CTRL) begin
            rdv = s.rg.ctrl;
        end else if (wb_i.adr == `LSP_ADR_STAT) begin
            rdv[`LSP_STAT_RDY]   = ready;
            rdv[`LSP_STAT_LED]   = s.led;
            rdv[`LSP_STAT_BUSY]  = (s.st != LSP_IDLE);
            rdv[`LSP_STAT_BLIND] = (s.st == LSP_BLIND);
            rdv[`LSP_STAT_ARMED] = s.armed;
        end else if (wb_i.adr == `LSP_ADR_CUR) begin
            rdv = s.rg.cur;
        end else if (wb_i.adr == `LSP_ADR_LEN) begin
            rdv = s.rg.len;
        end else if (wb_i.adr == `LSP_ADR_DLY) begin
            rdv = s.rg.dly;
        end else if (wb_i.adr == `LSP_ADR_START) begin
            rdv = s.rg.start;
        end else if (wb_i.adr == `LSP_ADR_CFG) begin
            rdv = s.rg.cfg;
        end else if (wb_i.adr == `LSP_ADR_FIX) begin
            rdv = s.rg.fix;
        end else if (wb_i.adr == `LSP_ADR_BLIND) begin
            rdv = s.rg.blind;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state: engine first, bus writes last
    always_comb begin
        n = s;
        case (s.st)
            LSP_IDLE: begin
                if (!trg && s.armed && reached) begin
                    n.armed = 1'b0;
                    if (act && (len16 != 16'h0000) && (!hwen || lvl)) begin
                        n.st    = LSP_PULSE;
                        n.cnt   = 20'(len16);
                        n.cur_q = s.rg.cur[15:0];
                    end
                end else if (trg && !hwen && ten && act && edg) begin
                    n.st  = LSP_DELAY;
                    n.cnt = dly_total;
                end
            end
            LSP_DELAY: begin
                if (t100) begin
                    if (s.cnt == 20'h00001) begin
                        n.st    = (len16 == 16'h0000) ? LSP_BLIND : LSP_PULSE;
                        n.cnt   = (len16 == 16'h0000) ? blind_eff : 20'(len16);
                        n.cur_q = s.rg.cur[15:0];
                    end else begin
                        n.cnt = s.cnt - 20'h00001;
                    end
                end
            end
            LSP_PULSE: begin
                if (ut) begin
                    if (s.cnt == 20'h00001) begin
                        n.st  = trg ? LSP_BLIND : LSP_IDLE;
                        n.cnt = trg ? blind_eff : 20'h00000;
                    end else begin
                        n.cnt = s.cnt - 20'h00001;
                    end
                end
            end
            LSP_BLIND: begin
                if (tus) begin
                    if (s.cnt == 20'h00001) begin
                        n.st = LSP_IDLE;
                    end else begin
                        n.cnt = s.cnt - 20'h00001;
                    end
                end
            end
            default: begin
                n.st = LSP_IDLE;
            end
        endcase

        if (!act) begin
            n.st  = LSP_IDLE;
            n.cnt = 20'h00000;
        end

        if (trg && hwen) begin
            n.led   = act && lvl;
            n.cur_q = s.rg.cur[15:0];
        end else begin
            n.led = act && (n.st == LSP_PULSE);
        end

        // Bus answer, one cycle per request
        n.ack  = wb_i.cyc && wb_i.stb && !s.ack;
        n.rdat = n.ack ? rdv : `LSP_RST_ZERO;

        // Register writes on the acknowledged edge
        if (wr) begin
            if (wb_i.adr == `LSP_ADR_CTRL) begin
                n.rg.ctrl = merge(s.rg.ctrl, `LSP_M_CTRL);
            end else if (wb_i.adr == `LSP_ADR_CUR) begin
                n.rg.cur = merge(s.rg.cur, `LSP_M_16);
            end else if (wb_i.adr == `LSP_ADR_LEN) begin
                n.rg.len = merge(s.rg.len, `LSP_M_16);
            end else if (wb_i.adr == `LSP_ADR_DLY) begin
                n.rg.dly = merge(s.rg.dly, `LSP_M_16);
            end else if (wb_i.adr == `LSP_ADR_START) begin
                n.rg.start = merge(s.rg.start, `LSP_M_32);
                n.armed    = 1'b1;
            end else if (wb_i.adr == `LSP_ADR_CFG) begin
                n.rg.cfg = merge(s.rg.cfg, `LSP_M_CFG);
            end else if (wb_i.adr == `LSP_ADR_FIX) begin
                n.rg.fix = merge(s.rg.fix, `LSP_M_16);
            end else if (wb_i.adr == `LSP_ADR_BLIND) begin
                n.rg.blind = merge(s.rg.blind, `LSP_M_16);
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.st       <= LSP_IDLE;
            s.rg.blind <= 32'(`LSP_BLIND_MIN_US);
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_o.ack             = s.ack;
    assign wb_o.dat             = s.rdat;
    assign led_output_channel_o = s.led;
    assign led_current_o        = s.cur_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ts_go;
        s.st == LSP_IDLE && !trg && s.armed && reached && act && len16 != 16'h0000 && (!hwen || lvl);
    endsequence

    sequence s_trig_go;
        s.st == LSP_IDLE && trg && !hwen && ten && act && edg;
    endsequence

    a_ts_start: assert property (s_ts_go |=> s.st == LSP_PULSE && s.led && s.cur_q == $past(s.rg.cur[15:0]))
        else $error("timestamp pulse did not start");
    a_no_drive: assert property (!s.rg.ctrl[`LSP_CTRL_EN] |=> !s.led)
        else $error("LED driven while enable clear");
    a_out_gate: assert property (s.led |-> $past(s.rg.ctrl[`LSP_CTRL_OUT]))
        else $error("LED driven while output bit clear");
    a_stop_idle: assert property (!act |=> s.st == LSP_IDLE && !s.led)
        else $error("pulse survived disable");
    a_hw_follow: assert property ((act && trg && hwen) ##1 (act && trg && hwen) |-> s.led == $past(lvl))
        else $error("LED not following trigger level");
    a_trig_delay: assert property (s_trig_go |=> s.st == LSP_DELAY && s.cnt == $past(dly_total))
        else $error("trigger delay total wrong");
    a_trig_cause: assert property ($rose(s.st == LSP_DELAY) |-> $past(edg) && $past(ten))
        else $error("delay entered without enabled trigger");
    a_pulse_ignore: assert property (s.st == LSP_PULSE |=> s.st != LSP_DELAY)
        else $error("trigger taken during pulse");
    a_blind_ignore: assert property (s.st == LSP_BLIND |=> s.st != LSP_DELAY && s.st != LSP_PULSE)
        else $error("trigger taken during blind time");
    a_blind_min: assert property ($rose(s.st == LSP_BLIND) |-> s.cnt >= 20'(`LSP_BLIND_MIN_US))
        else $error("blind time below floor");
    a_delay_pulse: assert property ((s.st == LSP_DELAY && t100 && s.cnt == 20'h00001 && act && len16 != 16'h0000)
                                    |=> s.st == LSP_PULSE && s.led)
        else $error("no pulse after delay");
    a_pulse_unit: assert property ((s.st == LSP_PULSE && !ut && act) |=> s.cnt == $past(s.cnt))
        else $error("pulse count moved without unit strobe");

    // Last unit of a pulse and of a blind wait
    sequence s_pulse_last;
        s.st == LSP_PULSE && ut && s.cnt == 20'h00001 && act && !hwen;
    endsequence

    sequence s_blind_last;
        s.st == LSP_BLIND && tus && s.cnt == 20'h00001 && act;
    endsequence

    a_pulse_end: assert property (s_pulse_last |=> !s.led && s.st == ($past(trg) ? LSP_BLIND : LSP_IDLE))
        else $error("pulse end took wrong path");
    a_blind_load: assert property ((s_pulse_last ##0 trg) |=> s.cnt == $past(blind_eff))
        else $error("blind count not loaded");
    a_blind_exit: assert property (s_blind_last |=> s.st == LSP_IDLE)
        else $error("blind wait did not end");

    a_delay_hold: assert property ((s.st == LSP_DELAY && !t100 && act) |=> s.cnt == $past(s.cnt))
        else $error("delay count moved without strobe");
    a_trig_gate: assert property ((s.st == LSP_IDLE && !ten) |=> s.st != LSP_DELAY)
        else $error("trigger taken without trigger enable");
    a_armed_drop: assert property ((s.st == LSP_IDLE && !trg && s.armed && reached && !wr) |=> !s.armed)
        else $error("start time stayed armed");

    a_cur_hold: assert property ((s.st == LSP_PULSE && !(trg && hwen)) |=> $stable(s.cur_q))
        else $error("current changed during pulse");
    a_hw_quiet: assert property ((trg && hwen && !lvl) |=> !s.led)
        else $error("LED on with trigger level low");
endmodule

// *** testbench/lsp_far_src.sv ***
// Far-side model: system time source and trigger comparators
module lsp_far_src (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  volt_i,
    output logic [31:0]      sys_time_o,
    output logic             hi_o,
    output logic             lo_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // System time in ns, one clock is 5 ns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_time_o <= 32'h0000_0000;
        end else begin
            sys_time_o <= sys_time_o + 32'h0000_0005;
        end
    end

    ////////////////////////////////////////////////////////////////
    // high and low thresholds
    assign hi_o = (volt_i >= 6'h0F);
    assign lo_o = (volt_i >= 6'h03);
endmodule

// *** testbench/led_strobe_pulse_sequencer_tb_top.sv ***
// Self-checking bench of the LED strobe pulse sequencer
`include "lsp_defs.svh"
module led_strobe_pulse_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import lsp_pkg::*;

    logic        clk_i;
    logic        rst_i;
    lsp_wb_req_t wb_req;
    lsp_wb_rsp_t wb_rsp;
    logic [31:0] sys_time;
    logic        hi;
    logic        lo;
    logic        led;
    logic [15:0] cur;
    logic [5:0]  volt;
    int          miscompares;
    int          samples_checked;
    int          n;
    logic [31:0] s;

    lsp_seq i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp), .sys_time_i(sys_time),
        .trigger_input_positive_hi_i(hi), .trigger_input_positive_lo_i(lo),
        .led_output_channel_o(led), .led_current_o(cur));
    lsp_far_src i_far (.clk_i(clk_i), .rst_i(rst_i), .volt_i(volt), .sys_time_o(sys_time), .hi_o(hi), .lo_o(lo));

    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Value and range comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input logic [31:0] v, input int lo_b, input int hi_b);
        samples_checked++;
        if ((v >= lo_b && v <= hi_b) !== 1'b1) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h..%h", $time, v, lo_b, hi_b);
        end
    endtask

    // One classic Wishbone cycle, waits for ack under a bound
    task automatic wb_cyc(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int k;
        k = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_rsp.ack !== 1'b1 && k < 20);
        rd = wb_rsp.dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        if (k >= 20) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            stop_test();
        end
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_cyc(1'b1, adr, dat, d);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_cyc(1'b0, adr, 32'h0000_0000, d);
        chk(d, exp);
    endtask

    // Cycles until the LED reaches a level, bounded
    task automatic wait_led(input logic lv, input int max, output int c);
        c = 0;
        while (led !== lv) begin
            @(posedge clk_i);
            c++;
            if (c > max) begin
                miscompares++;
                $display("ERROR at %0t: got %h expected %h", $time, led, lv);
                stop_test();
            end
        end
    endtask
    // LED must hold a level for a number of cycles
    task automatic stay(input logic lv, input int cyc);
        logic bad;
        bad = 1'b0;
        repeat (cyc) begin
            @(posedge clk_i);
            if (led !== lv) begin
                bad = 1'b1;
            end
        end
        chk(bad, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////
    // Reset values, masks, read-only and unmapped places
    task automatic test_regs();
        chk(led, 1'b0);
        rd_chk(`LSP_ADR_CTRL, 32'h0000_0000);
        rd_chk(`LSP_ADR_BLIND, 32'h0000_0014);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0000);
        wr(`LSP_ADR_CUR, 32'hABCD_1234);
        rd_chk(`LSP_ADR_CUR, 32'h0000_1234);
        wr(`LSP_ADR_STAT, 32'hFFFF_FFFF);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);
        wr(`LSP_ADR_LEN, 32'h0000_0003);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0001);
        $display("test regs done");
    endtask

    // Fine units, rising edge, summed delay, ignored and blind edges
    task automatic test_trig_fine();
        wr(`LSP_ADR_CFG, 32'h0000_0005);
        wr(`LSP_ADR_DLY, 32'h0000_0002);
        wr(`LSP_ADR_FIX, 32'h0000_0003);
        wr(`LSP_ADR_CTRL, 32'h0000_0004);
        wr(`LSP_ADR_CTRL, 32'h0000_0007);
        volt <= 6'h18;
        wait_led(1'b1, 700, n);
        rng(n, 498, 506);
        chk(cur, 32'h0000_1234);
        repeat (10) @(posedge clk_i);
        volt <= 6'h00;
        repeat (10) @(posedge clk_i);
        volt <= 6'h18;
        wait_led(1'b0, 100, n);
        rng(n + 20, 58, 62);
        rd_chk(`LSP_ADR_STAT, 32'h0000_000D);
        for (int i = 0; i < 4; i++) begin
            stay(1'b0, 400);
            volt <= 6'h00;
            stay(1'b0, 400);
            volt <= 6'h18;
        end
        stay(1'b0, 400);
        volt <= 6'h00;
        stay(1'b0, 600);
        volt <= 6'h18;
        wait_led(1'b1, 700, n);
        rng(n, 498, 506);
        wait_led(1'b0, 100, n);
        stay(1'b0, 4100);
        $display("test trig_fine done");
    endtask

    // Microsecond units, falling edge, low threshold, bare offset
    task automatic test_trig_coarse();
        wr(`LSP_ADR_CFG, 32'h0000_0019);
        wr(`LSP_ADR_DLY, 32'h0000_0000);
        wr(`LSP_ADR_FIX, 32'h0000_0000);
        wr(`LSP_ADR_LEN, 32'h0000_0001);
        volt <= 6'h0A;
        stay(1'b0, 600);
        volt <= 6'h00;
        wait_led(1'b1, 700, n);
        rng(n, 398, 406);
        wait_led(1'b0, 300, n);
        rng(n, 198, 202);
        stay(1'b0, 4100);
        $display("test trig_coarse done");
    endtask

    // Gating by trigger enable, enable, and abort on output clear
    task automatic test_gate();
        wr(`LSP_ADR_CFG, 32'h0000_0001);
        wr(`LSP_ADR_CTRL, 32'h0000_0003);
        volt <= 6'h18;
        stay(1'b0, 600);
        volt <= 6'h00;
        wr(`LSP_ADR_CTRL, 32'h0000_0006);
        volt <= 6'h18;
        stay(1'b0, 600);
        volt <= 6'h00;
        wr(`LSP_ADR_CTRL, 32'h0000_0007);
        volt <= 6'h18;
        wait_led(1'b1, 700, n);
        wr(`LSP_ADR_CTRL, 32'h0000_0005);
        wait_led(1'b0, 3, n);
        volt <= 6'h00;
        stay(1'b0, 20);
        $display("test gate done");
    endtask

    // Hardware enable follows the qualified level
    task automatic test_hwen();
        wr(`LSP_ADR_CFG, 32'h0000_0003);
        wr(`LSP_ADR_CTRL, 32'h0000_0007);
        volt <= 6'h18;
        wait_led(1'b1, 4, n);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0003);
        volt <= 6'h0A;
        wait_led(1'b0, 4, n);
        volt <= 6'h00;
        stay(1'b0, 10);
        $display("test hwen done");
    endtask

    // Timestamp pulse and output gating
    task automatic test_ts();
        wr(`LSP_ADR_CTRL, 32'h0000_0000);
        wr(`LSP_ADR_CFG, 32'h0000_0000);
        wr(`LSP_ADR_CUR, 32'h0000_0123);
        wr(`LSP_ADR_LEN, 32'h0000_0002);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0001);
        s = sys_time + 32'h0000_07D0;
        wr(`LSP_ADR_START, s);
        wr(`LSP_ADR_CTRL, 32'h0000_0003);
        wait_led(1'b1, 600, n);
        rng(int'(sys_time - s), 0, 20);
        chk(cur, 32'h0000_0123);
        wait_led(1'b0, 500, n);
        rng(n, 398, 402);
        wr(`LSP_ADR_CTRL, 32'h0000_0001);
        wr(`LSP_ADR_START, sys_time + 32'h0000_03E8);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0011);
        stay(1'b0, 600);
        rd_chk(`LSP_ADR_STAT, 32'h0000_0001);
        $display("test ts done");
    endtask

    ////////////////////////////////////////////////////////////////
    // Clock, 5 ns period
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        wb_req = '0;
        volt = 6'h00;
        miscompares = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_regs();
        test_trig_fine();
        test_trig_coarse();
        test_gate();
        test_hwen();
        test_ts();
        stop_test();
    end
endmodule
